// ===== common/rtc_pkg.sv
// shared constants and state types for the real-time clock block
package rtc_pkg;
   // timing
   localparam int CLK_FREQ_MHZ      = 20;
   localparam int UPD_TIME_US       = 3000;
   localparam int UPD_CNT_W         = 17;
   localparam int OSC_TICKS_PER_SEC = 32768;
   localparam int TRIM_STEP_TICKS   = 32;
   localparam int CORR_PER_HOUR     = 7;
   localparam int SEC_PER_HOUR      = 3600;
   localparam int SEC_PER_CORR      = SEC_PER_HOUR / CORR_PER_HOUR;
   localparam int MPL_UNIT_SHIFT    = 5;
   // register offsets and the value read back from unmapped addresses
   localparam logic [7:0] CAL_BASE     = 8'h60;
   localparam logic [7:0] ALM_BASE     = 8'h68;
   localparam logic [7:0] ALM_CTRL_OFS = 8'h78;
   localparam logic [7:0] TRIM_OFS     = 8'h79;
   localparam logic [7:0] STATUS_OFS   = 8'h7A;
   localparam logic [7:0] MPL_CTRL_OFS = 8'h81;
   localparam logic [7:0] REG_RESET    = 8'h00;
   // field order inside calendar and alarm groups
   localparam logic [2:0] F_SEC  = 3'h0;
   localparam logic [2:0] F_MIN  = 3'h1;
   localparam logic [2:0] F_HOUR = 3'h2;
   localparam logic [2:0] F_DAY  = 3'h3;
   localparam logic [2:0] F_MON  = 3'h4;
   localparam logic [2:0] F_YEAR = 3'h5;
   localparam logic [2:0] F_WDAY = 3'h6;
   // bit positions
   localparam int IGN_BIT       = 7;
   localparam int TRIM_SIGN_BIT = 7;
   localparam int MPL_EN_BIT    = 7;
   // field limits
   localparam logic [5:0] SEC_MAX  = 6'h3B;
   localparam logic [4:0] HOUR_MAX = 5'h17;
   localparam logic [3:0] MON_MAX  = 4'hC;
   localparam logic [6:0] YEAR_MAX = 7'h63;

   typedef struct packed {
      logic [1:0]  sync;
      logic        prev;
      logic [16:0] tick_cnt;
      logic [9:0]  sec_cnt;
      logic        corr;
   } rtc_pre_t;

   typedef struct packed {
      logic [1:0]           pwr_sync;
      logic                 pwr_prev;
      logic [5:0]           sec;
      logic [5:0]           min;
      logic [4:0]           hour;
      logic [4:0]           day;
      logic [3:0]           mon;
      logic [6:0]           year;
      logic [6:0]           wday;
      logic [1:0][6:0][7:0] alarm;
      logic [1:0]           act;
      logic [7:0]           trim;
      logic [7:0]           mpl_ctrl;
      logic [16:0]          upd_cnt;
      logic [11:0]          mpl_cnt;
      logic                 mpl_run;
      logic [1:0]           match_prev;
      logic                 irq;
      logic                 startup;
      logic                 mpl_evt;
      logic [7:0]           rdata;
   } rtc_st_t;
endpackage

// ===== hdl/rtc_prescaler.sv
// 32 kHz oscillator synchroniser and trimmed one-second divider
`timescale 1ns/1ns
module rtc_prescaler #(
   parameter int TICKS_PER_SEC = rtc_pkg::OSC_TICKS_PER_SEC
) (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       osc_i,
   input  wire logic [7:0] trim_i,
   input  wire logic       restart_i,
   output logic            osc_tick_o,
   output logic            sec_tick_o
);
   rtc_pkg::rtc_pre_t st;
   rtc_pkg::rtc_pre_t next_st;
   logic [16:0]       adj;
   logic [16:0]       period;

   // sync[0] is read only by sync[1]
   assign osc_tick_o = st.sync[1] & ~st.prev;
   // one code step moves 32 ticks per event, about 1.9 ppm over an hour
   assign adj = 17'({trim_i[6:0], 5'h00});
   always_comb begin
      if (!st.corr) begin
         period = 17'(TICKS_PER_SEC);
      end else if (trim_i[rtc_pkg::TRIM_SIGN_BIT]) begin
         period = 17'(TICKS_PER_SEC) - adj;
      end else begin
         period = 17'(TICKS_PER_SEC) + adj;
      end
   end
   assign sec_tick_o = osc_tick_o && (st.tick_cnt >= period - 17'h00001);

   always_comb begin
      next_st = st;
      next_st.sync = {st.sync[0], osc_i};
      next_st.prev = st.sync[1];
      if (restart_i) begin
         next_st.tick_cnt = 17'h00000;
      end else if (osc_tick_o) begin
         if (sec_tick_o) begin
            next_st.tick_cnt = 17'h00000;
            // seven corrected seconds per hour, evenly spaced
            if (st.sec_cnt == 10'(rtc_pkg::SEC_PER_CORR - 1)) begin
               next_st.sec_cnt = 10'h000;
               next_st.corr    = 1'b1;
            end else begin
               next_st.sec_cnt = st.sec_cnt + 10'h001;
               next_st.corr    = 1'b0;
            end
         end else begin
            next_st.tick_cnt = st.tick_cnt + 17'h00001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   property p_plain_sec;
      @(posedge clk_i) disable iff (srst_i)
      (sec_tick_o && !st.corr) |-> (st.tick_cnt == 17'(TICKS_PER_SEC - 1));
   endproperty
   a_plain_sec: assert property (p_plain_sec) else $error("second length wrong");
endmodule

// ===== hdl/rtc_alarm_match.sv
// compares the running time against one alarm
`timescale 1ns/1ns
module rtc_alarm_match (
   input  wire logic [5:0][6:0] cur_i,
   input  wire logic [6:0]      wday_i,
   input  wire logic [6:0][7:0] alarm_i,
   input  wire logic            active_i,
   output logic                 match_o
);
   logic [6:0] hit;

   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : g_field
         assign hit[i] = alarm_i[i][rtc_pkg::IGN_BIT] | (alarm_i[i][6:0] == cur_i[i]);
      end
   endgenerate
   // any set weekday bit that covers today is a hit
   assign hit[6] = alarm_i[6][rtc_pkg::IGN_BIT] | (|(alarm_i[6][6:0] & wday_i));
   assign match_o = active_i & (&hit);
endmodule

// ===== hdl/rtc_core.sv
// real-time clock, calendar, two alarms and momentary power-loss timer
`timescale 1ns/1ns
module rtc_core #(
   parameter int unsigned UPD_CYCLES = rtc_pkg::CLK_FREQ_MHZ * rtc_pkg::UPD_TIME_US
) (
   input  wire logic       CLK_I,
   input  wire logic       SRST_I,
   input  wire logic       OSC32K_I,
   input  wire logic       MAIN_PWR_I,
   input  wire logic       STANDBY_I,
   input  wire logic [7:0] REG_ADDR_I,
   input  wire logic [7:0] REG_WDATA_I,
   input  wire logic       REG_WR_I,
   input  wire logic       REG_RD_I,
   output logic      [7:0] REG_RDATA_O,
   output logic            ALARM_IRQ_O,
   output logic            STARTUP_REQ_O,
   output logic            MPL_EVENT_O
);
   localparam logic [16:0] UPD_LOAD = 17'(UPD_CYCLES - 1);

   rtc_pkg::rtc_st_t st;
   rtc_pkg::rtc_st_t next_st;
   logic             osc_tick;
   logic             sec_tick;
   logic             sec_restart;
   logic             cal_wr;
   logic             pwr_rise;
   logic             pwr_fall;
   logic [7:0]       cal_ofs;
   logic [7:0]       alm_ofs;
   logic             alm_wr;
   logic [5:0][6:0]  cur;
   logic [1:0]       match;
   logic [1:0]       ev;

   function automatic logic [7:0] field_mask(input logic [2:0] f);
      unique case (f)
         rtc_pkg::F_SEC, rtc_pkg::F_MIN:   field_mask = 8'h3F;
         rtc_pkg::F_HOUR, rtc_pkg::F_DAY:  field_mask = 8'h1F;
         rtc_pkg::F_MON:                   field_mask = 8'h0F;
         default:                          field_mask = 8'h7F;
      endcase
   endfunction

   function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
      unique case (m)
         4'h2:                   month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
         default:                month_days = 5'h1F;
      endcase
   endfunction

   function automatic logic [8:0] days_before(input logic [3:0] m);
      unique case (m)
         4'h2:    days_before = 9'h01F;
         4'h3:    days_before = 9'h03B;
         4'h4:    days_before = 9'h05A;
         4'h5:    days_before = 9'h078;
         4'h6:    days_before = 9'h097;
         4'h7:    days_before = 9'h0B5;
         4'h8:    days_before = 9'h0D4;
         4'h9:    days_before = 9'h0F3;
         4'hA:    days_before = 9'h111;
         4'hB:    days_before = 9'h130;
         4'hC:    days_before = 9'h14E;
         default: days_before = 9'h000;
      endcase
   endfunction

   // 2000-01-01 was a Saturday; index 0 is Monday
   function automatic logic [6:0] weekday_of(input logic [6:0] y, input logic [3:0] m,
                                             input logic [4:0] d);
      logic [15:0] days;
      logic [6:0]  y3;
      logic [2:0]  idx;
      y3   = y + 7'h03;
      days = {9'h000, y} * 16'h016D + {11'h000, y3[6:2]} + {7'h00, days_before(m)};
      if ((y[1:0] == 2'h0) && (m > 4'h2)) begin
         days = days + 16'h0001;
      end
      days = days + {11'h000, d} + 16'h0004;
      idx  = 3'(days % 16'h0007);
      weekday_of = 7'h01 << idx;
   endfunction

   rtc_prescaler #(
      .TICKS_PER_SEC (rtc_pkg::OSC_TICKS_PER_SEC)
   ) u_pre (
      .clk_i      (CLK_I),
      .srst_i     (SRST_I),
      .osc_i      (OSC32K_I),
      .trim_i     (st.trim),
      .restart_i  (sec_restart),
      .osc_tick_o (osc_tick),
      .sec_tick_o (sec_tick)
   );

   assign cur = {st.year, {3'h0, st.mon}, {2'h0, st.day},
                 {2'h0, st.hour}, {1'b0, st.min}, {1'b0, st.sec}};

   genvar a;
   generate
      for (a = 0; a < 2; a++) begin : g_alarm
         rtc_alarm_match u_match (
            .cur_i    (cur),
            .wday_i   (st.wday),
            .alarm_i  (st.alarm[a]),
            .active_i (st.act[a]),
            .match_o  (match[a])
         );
         assign ev[a] = match[a] & ~st.match_prev[a];
      end
   endgenerate

   assign cal_ofs     = REG_ADDR_I - rtc_pkg::CAL_BASE;
   assign alm_ofs     = REG_ADDR_I - rtc_pkg::ALM_BASE;
   // weekday offset is excluded, so software cannot overwrite it
   assign cal_wr      = REG_WR_I && (cal_ofs < 8'h06);
   assign alm_wr      = REG_WR_I && (alm_ofs < 8'h10) && (alm_ofs[2:0] != 3'h7);
   assign sec_restart = cal_wr && (cal_ofs[2:0] == rtc_pkg::F_SEC);
   assign pwr_rise    = st.pwr_sync[1] & ~st.pwr_prev;
   assign pwr_fall    = ~st.pwr_sync[1] & st.pwr_prev;

   always_comb begin
      next_st          = st;
      next_st.irq      = 1'b0;
      next_st.startup  = 1'b0;
      next_st.mpl_evt  = 1'b0;
      next_st.pwr_sync = {st.pwr_sync[0], MAIN_PWR_I};
      next_st.pwr_prev = st.pwr_sync[1];
      next_st.match_prev = match;
      next_st.wday     = weekday_of(st.year, st.mon, st.day);

      // readback is only trustworthy once this reaches zero
      if (cal_wr) begin
         next_st.upd_cnt = UPD_LOAD;
      end else if (st.upd_cnt != 17'h00000) begin
         next_st.upd_cnt = st.upd_cnt - 17'h00001;
      end

      // a write in the same cycle takes precedence over the advance
      if (sec_tick && !cal_wr) begin
         if (st.sec >= rtc_pkg::SEC_MAX) begin
            next_st.sec = 6'h00;
            if (st.min >= rtc_pkg::SEC_MAX) begin
               next_st.min = 6'h00;
               if (st.hour >= rtc_pkg::HOUR_MAX) begin
                  next_st.hour = 5'h00;
                  if (st.day >= month_days(st.mon, st.year)) begin
                     next_st.day = 5'h01;
                     if (st.mon >= rtc_pkg::MON_MAX) begin
                        next_st.mon  = 4'h1;
                        next_st.year = (st.year >= rtc_pkg::YEAR_MAX) ? 7'h00
                                                                      : st.year + 7'h01;
                     end else begin
                        next_st.mon = st.mon + 4'h1;
                     end
                  end else begin
                     next_st.day = st.day + 5'h01;
                  end
               end else begin
                  next_st.hour = st.hour + 5'h01;
               end
            end else begin
               next_st.min = st.min + 6'h01;
            end
         end else begin
            next_st.sec = st.sec + 6'h01;
         end
      end

      // one pulse per onset; the party in charge depends on power state
      if (|ev) begin
         if (STANDBY_I) begin
            next_st.startup = 1'b1;
         end else begin
            next_st.irq = 1'b1;
         end
      end

      // dropout timer counts oscillator ticks, not system clocks
      if (pwr_fall && st.mpl_ctrl[rtc_pkg::MPL_EN_BIT]) begin
         next_st.mpl_run = 1'b1;
         next_st.mpl_cnt = {st.mpl_ctrl[6:0], 5'h00};
      end else if (st.mpl_run) begin
         if (pwr_rise) begin
            next_st.mpl_evt = 1'b1;
            next_st.mpl_run = 1'b0;
         end else if (osc_tick) begin
            if (st.mpl_cnt == 12'h000) begin
               next_st.mpl_run = 1'b0;
            end else begin
               next_st.mpl_cnt = st.mpl_cnt - 12'h001;
            end
         end
      end
      if (pwr_rise) begin
         next_st.mpl_ctrl[rtc_pkg::MPL_EN_BIT] = 1'b0;
      end

      if (cal_wr) begin
         unique case (cal_ofs[2:0])
            rtc_pkg::F_SEC:  next_st.sec  = REG_WDATA_I[5:0];
            rtc_pkg::F_MIN:  next_st.min  = REG_WDATA_I[5:0];
            rtc_pkg::F_HOUR: next_st.hour = REG_WDATA_I[4:0];
            rtc_pkg::F_DAY:  next_st.day  = REG_WDATA_I[4:0];
            rtc_pkg::F_MON:  next_st.mon  = REG_WDATA_I[3:0];
            default:         next_st.year = REG_WDATA_I[6:0];
         endcase
      end
      if (alm_wr) begin
         next_st.alarm[alm_ofs[3]][alm_ofs[2:0]] =
            REG_WDATA_I & (field_mask(alm_ofs[2:0]) | 8'h80);
      end
      if (REG_WR_I && REG_ADDR_I == rtc_pkg::ALM_CTRL_OFS) begin
         next_st.act = REG_WDATA_I[1:0];
      end
      if (REG_WR_I && REG_ADDR_I == rtc_pkg::TRIM_OFS) begin
         next_st.trim = REG_WDATA_I;
      end
      if (REG_WR_I && REG_ADDR_I == rtc_pkg::MPL_CTRL_OFS) begin
         next_st.mpl_ctrl = REG_WDATA_I;
      end

      if (REG_RD_I) begin
         next_st.rdata = rtc_pkg::REG_RESET;
         if (cal_ofs < 8'h07) begin
            unique case (cal_ofs[2:0])
               rtc_pkg::F_SEC:  next_st.rdata = {2'h0, st.sec};
               rtc_pkg::F_MIN:  next_st.rdata = {2'h0, st.min};
               rtc_pkg::F_HOUR: next_st.rdata = {3'h0, st.hour};
               rtc_pkg::F_DAY:  next_st.rdata = {3'h0, st.day};
               rtc_pkg::F_MON:  next_st.rdata = {4'h0, st.mon};
               rtc_pkg::F_YEAR: next_st.rdata = {1'b0, st.year};
               default:         next_st.rdata = {1'b0, st.wday};
            endcase
         end else if ((alm_ofs < 8'h10) && (alm_ofs[2:0] != 3'h7)) begin
            next_st.rdata = st.alarm[alm_ofs[3]][alm_ofs[2:0]];
         end else if (REG_ADDR_I == rtc_pkg::ALM_CTRL_OFS) begin
            next_st.rdata = {6'h00, st.act};
         end else if (REG_ADDR_I == rtc_pkg::TRIM_OFS) begin
            next_st.rdata = st.trim;
         end else if (REG_ADDR_I == rtc_pkg::STATUS_OFS) begin
            next_st.rdata = {5'h00, st.mpl_run, st.pwr_sync[1], st.upd_cnt != 17'h00000};
         end else if (REG_ADDR_I == rtc_pkg::MPL_CTRL_OFS) begin
            next_st.rdata = st.mpl_ctrl;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign REG_RDATA_O   = st.rdata;
   assign ALARM_IRQ_O   = st.irq;
   assign STARTUP_REQ_O = st.startup;
   assign MPL_EVENT_O   = st.mpl_evt;

   property p_sec_wrap;
      @(posedge CLK_I) disable iff (SRST_I)
      (sec_tick && !cal_wr && st.sec == 6'h3B) |=> (st.sec == 6'h00);
   endproperty
   a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");

   property p_wday_onehot;
      @(posedge CLK_I) disable iff (SRST_I)
      $past(!SRST_I, 2) |-> $onehot(st.wday);
   endproperty
   a_wday_onehot: assert property (p_wday_onehot) else $error("weekday not one-hot");

   property p_upd_load;
      @(posedge CLK_I) disable iff (SRST_I)
      cal_wr ##1 !cal_wr |-> (st.upd_cnt == UPD_LOAD) ##1 (st.upd_cnt == UPD_LOAD - 17'h00001);
   endproperty
   a_upd_load: assert property (p_upd_load) else $error("update timer wrong");

   property p_irq_work;
      @(posedge CLK_I) disable iff (SRST_I)
      (|ev && !STANDBY_I) |=> (ALARM_IRQ_O && !STARTUP_REQ_O);
   endproperty
   a_irq_work: assert property (p_irq_work) else $error("missing alarm interrupt");

   property p_once;
      @(posedge CLK_I) disable iff (SRST_I)
      (ALARM_IRQ_O || STARTUP_REQ_O) |-> $past(|(match & ~st.match_prev));
   endproperty
   a_once: assert property (p_once) else $error("alarm output without onset");

   property p_mpl_load;
      @(posedge CLK_I) disable iff (SRST_I)
      (pwr_fall && st.mpl_ctrl[7])
         |=> st.mpl_run && (st.mpl_cnt == {$past(st.mpl_ctrl[6:0]), 5'h00});
   endproperty
   a_mpl_load: assert property (p_mpl_load) else $error("power-loss timer not loaded");

   property p_mpl_evt;
      @(posedge CLK_I) disable iff (SRST_I)
      MPL_EVENT_O |-> $past(st.mpl_run) && $past(pwr_rise) && !st.mpl_run;
   endproperty
   a_mpl_evt: assert property (p_mpl_evt) else $error("spurious power-loss event");

   property p_mpl_expire;
      @(posedge CLK_I) disable iff (SRST_I)
      (st.mpl_run && !pwr_rise && osc_tick && st.mpl_cnt == 12'h000)
         |=> !st.mpl_run ##1 !MPL_EVENT_O;
   endproperty
   a_mpl_expire: assert property (p_mpl_expire) else $error("expired timer still live");

   // a host write in the same cycle as the return may set the enable again
   property p_mpl_en_clear;
      @(posedge CLK_I) disable iff (SRST_I)
      (pwr_rise && !(REG_WR_I && REG_ADDR_I == rtc_pkg::MPL_CTRL_OFS))
         |=> !st.mpl_ctrl[rtc_pkg::MPL_EN_BIT];
   endproperty
   a_mpl_en_clear: assert property (p_mpl_en_clear) else $error("loss enable kept");
endmodule

// ===== testbench/rtc_host_model.sv
// host processor model on the register port of the clock core
`timescale 1ns/1ns
module rtc_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   initial begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // idle lines show the inverse so a stale value is never mistaken for data
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i);
      d = rdata_i;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] s;
      int         n;
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
      s = 8'h01;
      n = 0;
      // calendar readback is untrusted until the update sequence ends
      while (a >= 8'h60 && a <= 8'h65 && s[0] !== 1'b0 && n < 100) begin
         rd(8'h7A, s);
         n++;
      end
   endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the real-time clock core
`timescale 1ns/1ns
module tb_top;
   logic       clk;
   logic       srst;
   logic       osc;
   logic       main_pwr;
   logic       standby;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       irq;
   logic       start;
   logic       momentary_power_loss;
   logic [7:0] v;
   int         n_errors = 0;
   int         total_checks = 0;
   int         n_irq = 0;
   int         n_start = 0;
   int         n_mpl = 0;
   int         mdl[256] = '{default: 0};
   int         yy;
   int         mm;
   int         dd;

   rtc_core #(.UPD_CYCLES(20)) rtc_core_inst (
      .CLK_I(clk), .SRST_I(srst), .OSC32K_I(osc), .MAIN_PWR_I(main_pwr),
      .STANDBY_I(standby), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_RDATA_O(rdata), .ALARM_IRQ_O(irq), .STARTUP_REQ_O(start),
      .MPL_EVENT_O(momentary_power_loss)
   );
   rtc_host_model rtc_host_model_inst (
      .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // oscillator runs far above 32 kHz so that one second fits the run
   initial begin
      osc = 1'b0;
      forever @(posedge clk) osc <= ~osc;
   end
   always @(posedge clk) begin
      if (irq === 1'b1) n_irq++;
      if (start === 1'b1) n_start++;
      if (momentary_power_loss === 1'b1) n_mpl++;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   function automatic int fmask(input int a);
      int f[7] = '{8'h3F, 8'h3F, 8'h1F, 8'h1F, 8'h0F, 8'h7F, 8'h7F};
      if (a >= 8'h60 && a <= 8'h65) return f[a - 8'h60];
      if ((a >= 8'h68 && a <= 8'h6E) || (a >= 8'h70 && a <= 8'h76)) return 8'h80 | f[a % 8];
      if (a == 8'h78) return 8'h03;
      if (a == 8'h79 || a == 8'h81) return 8'hFF;
      return 0;
   endfunction
   // days since the first of January 2000, a Saturday; Monday is bit 0
   function automatic int wday(input int y, input int m, input int d);
      int cm[12] = '{0, 31, 59, 90, 120, 151, 181, 212, 243, 273, 304, 334};
      int n;
      n = y * 365 + (y + 3) / 4 + cm[m - 1] + d - 1;
      if (m > 2 && y % 4 == 0) n++;
      return 1 << ((n + 5) % 7);
   endfunction
   task automatic put(input int a, input int d);
      rtc_host_model_inst.wr(8'(a), 8'(d));
      if (a != 8'h66) mdl[a] = d & fmask(a);
      if (mdl[8'h64] inside {[1:12]}) mdl[8'h66] = wday(mdl[8'h65], mdl[8'h64], mdl[8'h63]);
   endtask
   task automatic cmp(input int a);
      rtc_host_model_inst.rd(8'(a), v);
      chk($sformatf("reg %0h", a), v, mdl[a]);
   endtask
   task automatic ploss(input int hold, input int st);
      @(posedge clk);
      main_pwr <= 1'b0;
      repeat (hold) @(posedge clk);
      rtc_host_model_inst.rd(8'h7A, v);
      chk("loss status", v, st);
      @(posedge clk);
      main_pwr <= 1'b1;
      repeat (10) @(posedge clk);
      mdl[8'h81] &= 8'h7F;
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'hFE76));
      srst = 1'b1;
      main_pwr = 1'b1;
      standby = 1'b0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      for (int a = 8'h60; a <= 8'h81; a++)
         if (a != 8'h66 && a != 8'h7A) cmp(a);
      for (int a = 8'h60; a <= 8'h81; a++) begin
         put(a, $urandom);
         if (a != 8'h66 && a != 8'h7A) cmp(a);
      end
      repeat (6) begin
         yy = $urandom % 100;
         mm = 1 + $urandom % 12;
         dd = 1 + $urandom % 28;
         put(8'h65, yy);
         put(8'h64, mm);
         put(8'h63, dd);
         put(8'h66, $urandom);
         cmp(8'h66);
      end
      put(8'h78, 0);
      for (int a = 8'h69; a <= 8'h6E; a++) put(a, 8'h80);
      for (int a = 8'h70; a <= 8'h75; a++) put(a, 8'h80);
      put(8'h68, 30);
      put(8'h60, 31);
      n_irq = 0;
      n_start = 0;
      put(8'h60, 30);
      chk("irq inactive", n_irq, 0);
      put(8'h60, 31);
      put(8'h78, 1);
      put(8'h60, 30);
      repeat (8) @(posedge clk);
      chk("irq once", n_irq, 1);
      chk("no start", n_start, 0);
      standby <= 1'b1;
      put(8'h76, ~mdl[8'h66] & 8'h7F);
      put(8'h78, 2);
      chk("start wrong day", n_start, 0);
      put(8'h76, 8'h7F);
      repeat (8) @(posedge clk);
      chk("start once", n_start, 1);
      chk("irq total", n_irq, 1);
      put(8'h81, 8'h82);
      ploss(40, 8'h04);
      chk("mpl event", n_mpl, 1);
      cmp(8'h81);
      put(8'h81, 8'h82);
      ploss(400, 8'h00);
      chk("mpl expired", n_mpl, 1);
      ploss(40, 8'h00);
      chk("mpl disabled", n_mpl, 1);
      put(8'h78, 0);
      put(8'h65, 0);
      put(8'h64, 2);
      put(8'h63, 28);
      put(8'h62, 23);
      put(8'h61, 59);
      put(8'h60, 59);
      v = 8'h3B;
      for (int i = 0; i < 30000 && v !== 8'h00; i++) rtc_host_model_inst.rd(8'h60, v);
      mdl[8'h60] = 0;
      mdl[8'h61] = 0;
      mdl[8'h62] = 0;
      mdl[8'h63] = 29;
      mdl[8'h66] = wday(0, 2, 29);
      for (int a = 8'h60; a <= 8'h66; a++) cmp(a);
      end_of_test();
   end
endmodule
